// >>> conv_i2c_assertions.sv
// Purpose: Protocol checks on the link joining controller and target
// Assumes: Both ends and the link lines live on clk_i
// Notes: Helper state tracks start, bit count and addressed direction
module conv_i2c_assertions
  import i2c_conv_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset, high
  input wire logic ctl_scl_o, // Controller clock level
  input wire logic ctl_scl_oe_n, // Controller clock pull
  input wire logic ctl_sda_o, // Controller data level
  input wire logic ctl_sda_oe_n, // Controller data pull
  input wire logic tgt_sda_o, // Target data level
  input wire logic tgt_sda_oe_n, // Target data pull
  input wire logic scl, // Resolved clock line
  input wire logic sda // Resolved data line
);
  typedef struct packed {
    logic scl;
    logic sda;
    logic act;
    logic first;
    logic wr;
    logic rd;
    logic [3:0] cnt;
    logic [7:0] sh;
  } mon_t;
  mon_t s_q;
  mon_t s_d;
  logic start_w;
  logic stop_w;
  logic rise_w;
  logic nine_w;

  // Line events against the previous sample
  assign start_w = scl && s_q.scl && s_q.sda && !sda;
  assign stop_w = scl && s_q.scl && !s_q.sda && sda;
  assign rise_w = scl && !s_q.scl;
  assign nine_w = rise_w && s_q.act && (s_q.cnt == 4'h8);

  // Follow transfer, bit count and direction
  always_comb
  begin
    s_d = s_q;
    s_d.scl = scl;
    s_d.sda = sda;
    if (start_w)
    begin
      s_d.act = 1'b1;
      s_d.first = 1'b1;
      s_d.cnt = 4'h0;
    end
    else if (stop_w)
      s_d.act = 1'b0;
    else if (rise_w && s_q.act)
    begin
      s_d.cnt = nine_w ? 4'h0 : s_q.cnt + 4'h1;
      s_d.sh = {s_q.sh[6:0], sda};
      if (nine_w && s_q.first)
      begin
        s_d.first = 1'b0;
        s_d.wr = (s_q.sh[7:1] == TARGET_ADDR) && !s_q.sh[0];
        s_d.rd = (s_q.sh[7:1] == TARGET_ADDR) && s_q.sh[0];
      end
    end
  end

  // Helper register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence hi_hold;
    scl ##1 scl;
  endsequence

  AST_ADDR_ACK: // address match
  assert property (nine_w && s_q.first |-> tgt_sda_oe_n == (s_q.sh[7:1] != TARGET_ADDR))
    else $error("address acknowledge wrong");
  AST_ADDR_QUIET: // silent in address
  assert property (s_q.act && s_q.first && scl && !rise_w && s_q.cnt != 4'h0 |-> tgt_sda_oe_n)
    else $error("target pulls during address bits");
  AST_WR_ACK: // byte acknowledge
  assert property (nine_w && !s_q.first && s_q.wr |-> !tgt_sda_oe_n)
    else $error("written byte not acknowledged");
  AST_WR_QUIET: // silent while written
  assert property (s_q.act && !s_q.first && s_q.wr && scl && !rise_w && s_q.cnt != 4'h0
                   |-> tgt_sda_oe_n)
    else $error("target pulls during written bits");
  AST_RD_FREE: // target free for receiver acknowledge
  assert property (nine_w && !s_q.first && s_q.rd |-> tgt_sda_oe_n)
    else $error("target holds data in acknowledge slot");
  AST_TGT_STABLE: // target holds data
  assert property (hi_hold |-> $stable(tgt_sda_oe_n))
    else $error("target data moved while clock high");
  AST_CTL_STABLE: // controller holds data
  assert property (hi_hold ##0 $changed(ctl_sda_oe_n) |-> s_q.cnt <= 4'h1)
    else $error("controller data moved inside a byte");
  AST_STOP_IDLE: // idle after stop
  assert property (stop_w |=> tgt_sda_oe_n [*4])
    else $error("target drives after stop");
  AST_PULL_LOW: // drivers only pull low
  assert property (!ctl_scl_o && !ctl_sda_o && !tgt_sda_o)
    else $error("open-drain driver level not low");
endmodule

// >>> conv_i2c_controller.sv
// Purpose: Two-wire bus controller ordered over classic Wishbone
// Assumes: Single target; no clock stretching; 100 MHz clock
// Notes: Clock line made by a quarter-period divider
module conv_i2c_controller
  import i2c_conv_pkg::*;
#(
  parameter int BUS_RATE_HZ = RATE_FAST_PLUS_HZ // Link bit rate
)
(
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset, high
  i2c_link_if.controller bus, // Two-wire link
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [3:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o // Acknowledge
);
  localparam int QUARTER = CLK_FREQ_HZ / (4 * BUS_RATE_HZ);
  localparam logic [15:0] Q_LAST = 16'(QUARTER - 1);

  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_START = 4'b0010,
    H_BITS = 4'b0100,
    H_STOP = 4'b1000
  } ctl_state_t;

  typedef struct packed {
    ctl_state_t st;
    logic [15:0] qc;
    logic [1:0] ph;
    logic [3:0] bit_i;
    logic [1:0] bsel;
    logic rd;
    logic [7:0] regad;
    logic [7:0] data;
    logic [7:0] rx;
    logic nack;
    logic scl_low;
    logic sda_low;
    logic [1:0] sda_s;
    logic ack;
    logic [31:0] dat;
  } ctl_reg_t;

  ctl_reg_t q;
  ctl_reg_t d;
  logic [7:0] tx_byte;
  logic req;
  logic tick;

  assign req = wb_cyc_i & wb_stb_i & ~q.ack;
  assign tick = (q.st != H_IDLE) && (q.qc == Q_LAST);

  // Byte on the wire for the current position
  // [RULE_11] Address, register, then data
  // [RULE_08] Direction bit values
  always_comb
  begin
    unique case (q.bsel)
      2'd0: tx_byte = {TARGET_ADDR, DIR_WRITE};
      2'd1: tx_byte = q.regad;
      2'd2: tx_byte = q.rd ? {TARGET_ADDR, DIR_READ} : q.data;
      2'd3: tx_byte = 8'hFF;
    endcase
  end

  // Next-state logic: Wishbone slave and bit sequencer
  always_comb
  begin
    d = q;
    d.sda_s = {q.sda_s[0], bus.sda};
    d.ack = req;
    if (req && !wb_we_i)
    begin
      d.dat = '0;
      if (wb_adr_i == STATUS_OFS)
      begin
        d.dat[STAT_BUSY_BIT] = (q.st != H_IDLE);
        d.dat[STAT_NACK_BIT] = q.nack;
        d.dat[15:8] = q.rx;
      end
      else if (wb_adr_i == CMD_OFS)
      begin
        d.dat = {15'd0, q.rd, q.regad, q.data};
      end
    end
    if (req && wb_we_i && wb_adr_i == CMD_OFS && wb_sel_i[2:0] == 3'b111 && q.st == H_IDLE)
    begin
      d.data = wb_dat_i[7:0];
      d.regad = wb_dat_i[15:8];
      d.rd = wb_dat_i[CMD_READ_BIT];
      d.nack = 1'b0;
      d.bsel = 2'd0;
      d.ph = 2'd0;
      d.qc = '0;
      // [RULE_03] Same sequence at any rate
      d.st = H_START;
    end
    if (q.st != H_IDLE)
    begin
      d.qc = tick ? 16'd0 : q.qc + 16'd1;
    end
    if (tick)
    begin
      d.ph = q.ph + 2'd1;
      unique case (q.st)
        H_IDLE:
        begin
          d.ph = q.ph;
        end
        H_START:
        begin
          // [RULE_04] Data falls while clock high
          if (q.ph == 2'd0) d.sda_low = 1'b0;
          if (q.ph == 2'd1) d.scl_low = 1'b0;
          if (q.ph == 2'd2) d.sda_low = 1'b1;
          if (q.ph == 2'd3)
          begin
            d.scl_low = 1'b1;
            d.bit_i = 4'd0;
            d.st = H_BITS;
          end
        end
        H_BITS:
        begin
          // [RULE_06] Data set only in low phase
          // [RULE_09] Ninth bit released for acknowledge
          if (q.ph == 2'd0) d.sda_low = (q.bit_i < 4'd8) && !tx_byte[3'(4'd7 - q.bit_i)];
          if (q.ph == 2'd1) d.scl_low = 1'b0;
          if (q.ph == 2'd2)
          begin
            if (q.bit_i < 4'd8 && q.bsel == 2'd3) d.rx = {q.rx[6:0], q.sda_s[1]};
            if (q.bit_i == 4'd8 && q.bsel != 2'd3) d.nack = q.sda_s[1];
          end
          if (q.ph == 2'd3)
          begin
            d.scl_low = 1'b1;
            d.bit_i = q.bit_i + 4'd1;
            if (q.bit_i == 4'd8)
            begin
              d.bit_i = 4'd0;
              if (q.nack || q.bsel == 2'd3 || (q.bsel == 2'd2 && !q.rd))
              begin
                d.st = H_STOP;
              end
              else if (q.bsel == 2'd1 && q.rd)
              begin
                d.bsel = 2'd2;
                d.st = H_START;
              end
              else
              begin
                d.bsel = q.bsel + 2'd1;
              end
            end
          end
        end
        H_STOP:
        begin
          // [RULE_05] Data rises while clock high
          if (q.ph == 2'd0) d.sda_low = 1'b1;
          if (q.ph == 2'd1) d.scl_low = 1'b0;
          if (q.ph == 2'd2) d.sda_low = 1'b0;
          if (q.ph == 2'd3) d.st = H_IDLE;
        end
      endcase
    end
  end

  // State register; reset leaves both lines low so a stop follows
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      // [RULE_14] Stop issued after power-up
      q.st <= H_STOP;
      q.scl_low <= 1'b1;
      q.sda_low <= 1'b1;
      q.sda_s <= 2'b11;
    end
    else
    begin
      q <= d;
    end
  end

  assign bus.ctl_scl_o = 1'b0;
  assign bus.ctl_scl_oe_n = ~q.scl_low;
  assign bus.ctl_sda_o = 1'b0;
  assign bus.ctl_sda_oe_n = ~q.sda_low;
  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.dat;
endmodule

// >>> conv_i2c_target.sv
// Purpose: Two-wire register target and control bank of a buck-boost converter
// Assumes: Controller drives the clock line; no clock stretching
// Notes: Link lines and enable pin are synchronised to clk_i before use
// Summary of operation
// [RULE_01] Decode seven-bit addresses only
// [RULE_02] Acknowledge only address 0101010
// [RULE_03] Same protocol at all three rates
// [RULE_04] Falling data while clock high starts
// [RULE_05] Rising data while clock high stops, idle
// [RULE_06] Data changes only while clock low
// [RULE_07] Matching address acknowledged on ninth pulse
// [RULE_08] Direction zero writes, one reads
// [RULE_09] Each byte followed by receiver acknowledge
// [RULE_10] Unmapped register reads return zero
// [RULE_11] Write: start, address, register, data
// [RULE_12] Acknowledge bytes; commit at acknowledge end
// [RULE_13] Power-on reset restores register defaults
// [RULE_14] Controller sends stop after power-up
// [RULE_15] Registers at 02, 03, 05; first resets 08
// [RULE_16] Second control register resets to 45
// [RULE_17] Unused bits ignore writes, read zero
// [RULE_18] Bit 3 selects fast slew, resets one
// [RULE_19] Bit 2 enables hiccup timer
// [RULE_20] Output on when bit 0 and pin
// [RULE_21] Voltage code maps, saturates above B4
// [RULE_22] Enable pin low restores defaults
// [RULE_23] Second control register field layout
module conv_i2c_target
  import i2c_conv_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Power-on reset, synchronous, high
  i2c_link_if.target bus, // Two-wire link
  input wire logic en_pin_i, // External enable pin, asynchronous
  output logic converter_on_o, // Converter output enabled
  output logic fast_slew_select_o, // Fast voltage slew
  output logic hiccup_protect_enable_o, // Hiccup timer enable
  output logic [7:0] vout_code_o, // Output voltage code
  output logic [12:0] vout_mv_o, // Selected output voltage, millivolts
  output logic forced_pulse_width_select_o, // Forced PWM
  output logic fast_ramp_o, // Fast start-up ramp
  output logic [1:0] discharge_strength_o, // Output discharge level
  output logic startup_current_floor_o, // Start-up current floor
  output logic [2:0] ramp_time_select_o // Soft-start ramp time code
);
  typedef enum logic [4:0] {
    T_IDLE = 5'b00001,
    T_RX = 5'b00010,
    T_ACK = 5'b00100,
    T_TX = 5'b01000,
    T_TXACK = 5'b10000
  } tgt_state_t;

  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_REG = 2'b01,
    PH_DATA = 2'b10
  } byte_phase_t;

  typedef struct packed {
    tgt_state_t st;
    byte_phase_t phase;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rd;
    logic nack;
    logic [7:0] ptr;
    logic sda_low;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [1:0] en_s;
    logic fast;
    logic hic;
    logic conv;
    logic [7:0] vout;
    logic [7:0] ctlb;
    logic on;
    logic [12:0] mv;
  } tgt_reg_t;

  tgt_reg_t q;
  tgt_reg_t d;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  // Read value of the register at a pointer
  function automatic logic [7:0] read_mux(input tgt_reg_t r, input logic [7:0] p);
    logic [7:0] v;
    v = READ_FILL;
    // [RULE_17] Unused bits read zero
    if (p == CTRL_A_OFS)
    begin
      v[FAST_SLEW_BIT] = r.fast;
      v[HICCUP_BIT] = r.hic;
      v[CONV_EN_BIT] = r.conv;
    end
    else if (p == VOUT_OFS)
    begin
      v = r.vout;
    end
    else if (p == CTRL_B_OFS)
    begin
      v = r.ctlb;
    end
    // [RULE_10] Unmapped gives zero
    return v;
  endfunction

  // Edge and condition detection on the second synchroniser stage onward
  // [RULE_04] Start detect
  assign start_seen = q.scl_s[1] & q.scl_s[2] & q.sda_s[2] & ~q.sda_s[1];
  // [RULE_05] Stop detect
  assign stop_seen = q.scl_s[1] & q.scl_s[2] & ~q.sda_s[2] & q.sda_s[1];
  assign scl_rise = q.scl_s[1] & ~q.scl_s[2];
  assign scl_fall = ~q.scl_s[1] & q.scl_s[2];

  // Next-state logic for protocol engine and register bank
  always_comb
  begin
    d = q;
    d.scl_s = {q.scl_s[1:0], bus.scl};
    d.sda_s = {q.sda_s[1:0], bus.sda};
    d.en_s = {q.en_s[0], en_pin_i};
    // [RULE_03] Edge-driven, rate independent
    unique case (q.st)
      T_IDLE:
      begin
        d.sda_low = 1'b0;
      end
      T_RX:
      begin
        if (scl_rise)
        begin
          d.sh = {q.sh[6:0], q.sda_s[1]};
          d.cnt = q.cnt + 4'd1;
        end
        else if (scl_fall && q.cnt == 4'd8)
        begin
          d.cnt = 4'd0;
          // [RULE_12] Acknowledge each received byte
          d.st = T_ACK;
          d.sda_low = 1'b1;
          if (q.phase == PH_ADDR)
          begin
            // [RULE_01] Only seven-bit match
            // [RULE_02] Fixed address compare
            if (q.sh[7:1] == TARGET_ADDR)
            begin
              // [RULE_08] Direction bit sense
              d.rd = (q.sh[0] == DIR_READ);
            end
            else
            begin
              // [RULE_07] Stay released on mismatch
              d.st = T_IDLE;
              d.sda_low = 1'b0;
            end
          end
          else if (q.phase == PH_REG)
          begin
            d.ptr = q.sh;
          end
        end
      end
      T_ACK:
      begin
        // [RULE_07] Held low through ninth high
        if (scl_fall)
        begin
          d.sda_low = 1'b0;
          d.cnt = 4'd0;
          if (q.phase == PH_DATA)
          begin
            // [RULE_12] Commit on acknowledge falling edge
            if (q.ptr == CTRL_A_OFS)
            begin
              // [RULE_17] Unused bits ignored
              // [RULE_18] Fast slew bit
              d.fast = q.sh[FAST_SLEW_BIT];
              // [RULE_19] Hiccup enable bit
              d.hic = q.sh[HICCUP_BIT];
              d.conv = q.sh[CONV_EN_BIT];
            end
            else if (q.ptr == VOUT_OFS)
            begin
              d.vout = q.sh;
            end
            else if (q.ptr == CTRL_B_OFS)
            begin
              d.ctlb = q.sh;
            end
            d.ptr = q.ptr + 8'd1;
            d.st = T_RX;
          end
          else if (q.phase == PH_ADDR && q.rd)
          begin
            // [RULE_06] First bit set while clock low
            d.sh = read_mux(q, q.ptr);
            d.sda_low = ~d.sh[7];
            d.st = T_TX;
          end
          else
          begin
            d.phase = (q.phase == PH_ADDR) ? PH_REG : PH_DATA;
            d.st = T_RX;
          end
        end
      end
      T_TX:
      begin
        if (scl_fall)
        begin
          d.cnt = q.cnt + 4'd1;
          if (q.cnt == 4'd7)
          begin
            // [RULE_09] Release for controller acknowledge
            d.sda_low = 1'b0;
            d.st = T_TXACK;
          end
          else
          begin
            d.sh = {q.sh[6:0], 1'b0};
            d.sda_low = ~q.sh[6];
          end
        end
      end
      T_TXACK:
      begin
        if (scl_rise)
        begin
          d.nack = q.sda_s[1];
        end
        else if (scl_fall)
        begin
          d.cnt = 4'd0;
          if (q.nack)
          begin
            d.st = T_IDLE;
          end
          else
          begin
            d.ptr = q.ptr + 8'd1;
            d.sh = read_mux(q, d.ptr);
            d.sda_low = ~d.sh[7];
            d.st = T_TX;
          end
        end
      end
    endcase
    if (start_seen)
    begin
      d.st = T_RX;
      d.phase = PH_ADDR;
      d.cnt = 4'd0;
      d.sda_low = 1'b0;
    end
    else if (stop_seen)
    begin
      d.st = T_IDLE;
      d.sda_low = 1'b0;
    end
    // [RULE_22] Enable pin low restores defaults
    if (!q.en_s[1])
    begin
      d.st = T_IDLE;
      d.sda_low = 1'b0;
      d.fast = CTRL_A_RST[FAST_SLEW_BIT];
      d.hic = CTRL_A_RST[HICCUP_BIT];
      d.conv = CTRL_A_RST[CONV_EN_BIT];
      d.vout = VOUT_RST;
      d.ctlb = CTRL_B_RST;
    end
    // [RULE_20] Output needs bit and pin
    d.on = q.conv & q.en_s[1];
    // [RULE_21] Code to millivolts with saturation
    if (q.vout <= VOUT_MAX_CODE)
    begin
      d.mv = 13'(VOUT_BASE_MV + VOUT_STEP_MV * int'(q.vout));
    end
    else
    begin
      d.mv = 13'(VOUT_TOP_MV);
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.st <= T_IDLE;
      q.phase <= PH_ADDR;
      q.scl_s <= 3'b111;
      q.sda_s <= 3'b111;
      // [RULE_13] Power-on defaults
      // [RULE_15] First control and voltage defaults
      q.fast <= CTRL_A_RST[FAST_SLEW_BIT];
      q.hic <= CTRL_A_RST[HICCUP_BIT];
      q.conv <= CTRL_A_RST[CONV_EN_BIT];
      q.vout <= VOUT_RST;
      // [RULE_16] Second control default
      q.ctlb <= CTRL_B_RST;
      q.mv <= 13'd0;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs from the state register
  assign bus.tgt_sda_o = 1'b0;
  assign bus.tgt_sda_oe_n = ~q.sda_low;
  assign converter_on_o = q.on;
  assign fast_slew_select_o = q.fast;
  assign hiccup_protect_enable_o = q.hic;
  assign vout_code_o = q.vout;
  assign vout_mv_o = q.mv;
  // [RULE_23] Second control field layout
  assign forced_pulse_width_select_o = q.ctlb[FORCED_PULSE_WIDTH_SELECT_BIT];
  assign fast_ramp_o = q.ctlb[FAST_RAMP_BIT];
  assign discharge_strength_o = q.ctlb[DISCH_LSB +: 2];
  assign startup_current_floor_o = q.ctlb[CUR_FLOOR_BIT];
  assign ramp_time_select_o = q.ctlb[RAMP_LSB +: 3];
endmodule

// >>> i2c_conv_pkg.sv
// Purpose: Shared constants for the converter register target and its bus controller
// Assumes: 100 MHz system clock on both ends
// Notes: Register offsets and reset values are those of the converter map
package i2c_conv_pkg;
  // Bus identity and clocking
  localparam logic [6:0] TARGET_ADDR = 7'h2A;
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int RATE_STD_HZ = 100_000;
  localparam int RATE_FAST_HZ = 400_000;
  localparam int RATE_FAST_PLUS_HZ = 1_000_000;

  // Converter register map
  localparam logic [7:0] CTRL_A_OFS = 8'h02;
  localparam logic [7:0] VOUT_OFS = 8'h03;
  localparam logic [7:0] CTRL_B_OFS = 8'h05;
  localparam logic [7:0] CTRL_A_RST = 8'h08;
  localparam logic [7:0] VOUT_RST = 8'h5C;
  localparam logic [7:0] CTRL_B_RST = 8'h45;
  localparam logic [7:0] READ_FILL = 8'h00;

  // First control register fields
  localparam int FAST_SLEW_BIT = 3;
  localparam int HICCUP_BIT = 2;
  localparam int CONV_EN_BIT = 0;

  // Second control register fields
  localparam int FORCED_PULSE_WIDTH_SELECT_BIT = 7;
  localparam int FAST_RAMP_BIT = 6;
  localparam int DISCH_LSB = 4;
  localparam int CUR_FLOOR_BIT = 3;
  localparam int RAMP_LSB = 0;

  // Output voltage code conversion
  localparam logic [7:0] VOUT_MAX_CODE = 8'hB4;
  localparam int VOUT_BASE_MV = 1000;
  localparam int VOUT_STEP_MV = 25;
  localparam int VOUT_TOP_MV = 5500;

  // Controller Wishbone registers
  localparam logic [3:0] CMD_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam int CMD_READ_BIT = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NACK_BIT = 1;

  // Transfer direction bit values
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
endpackage

// >>> i2c_link_if.sv
// Purpose: Two-wire link joining controller and target, with wired-AND resolution
// Assumes: Open-drain drivers; an enable low means the pin is pulled to the out value
// Notes: Both lines read high when nobody pulls
interface i2c_link_if;
  logic ctl_scl_o;
  logic ctl_scl_oe_n;
  logic ctl_sda_o;
  logic ctl_sda_oe_n;
  logic tgt_sda_o;
  logic tgt_sda_oe_n;
  logic scl;
  logic sda;

  // Pull-up with wired-AND of every enabled driver
  assign scl = ctl_scl_oe_n | ctl_scl_o;
  assign sda = (ctl_sda_oe_n | ctl_sda_o) & (tgt_sda_oe_n | tgt_sda_o);

  modport controller (output ctl_scl_o, ctl_scl_oe_n, ctl_sda_o, ctl_sda_oe_n, input scl, sda);
  modport target (output tgt_sda_o, tgt_sda_oe_n, input scl, sda);
endinterface

// >>> tb_converter_i2c_target_regs.sv
// Purpose: Self-checking bench for the converter link target and controller
// Assumes: 100 MHz clock; controller at the fast-plus rate
// Notes: A second link lets the bench send raw address bytes to a target
module tb_converter_i2c_target_regs
  import i2c_conv_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BQ = 4; // Raw link quarter, link clock period 160 ns
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic en_pin = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [3:0] wb_adr = 4'h0;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0000_0000;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic conv_on, fast_slew, hiccup, fpw, framp, floor_sel;
  logic [7:0] vout_code;
  logic [12:0] vout_mv;
  logic [1:0] disch;
  logic [2:0] ramp;
  logic [7:0] m_a, m_v, m_b, got, ra;
  logic [31:0] st, r;
  logic [31:0] seed = 32'h77b6_ebfd;
  logic ack;
  logic [7:0] offs [5] = '{8'h02, 8'h03, 8'h05, 8'h00, 8'h06};
  logic [7:0] atab [5] = '{8'h54, 8'h56, 8'h00, 8'hF0, 8'h14};
  int mismatches = 0;
  int tests_run = 0;

`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin mismatches++; \
  $display("ERROR %s expected %0h seen %0h", nm, (ex), (gt)); end end

  // Clock
  always #5 clk_i = ~clk_i;

  i2c_link_if link_a();
  i2c_link_if link_b();
  conv_i2c_controller #(.BUS_RATE_HZ(RATE_FAST_PLUS_HZ)) conv_i2c_controller_inst (
    .clk_i(clk_i), .rst_i(rst_i), .bus(link_a), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));
  conv_i2c_target conv_i2c_target_inst (.clk_i(clk_i), .rst_i(rst_i), .bus(link_a),
    .en_pin_i(en_pin), .converter_on_o(conv_on), .fast_slew_select_o(fast_slew),
    .hiccup_protect_enable_o(hiccup), .vout_code_o(vout_code), .vout_mv_o(vout_mv),
    .forced_pulse_width_select_o(fpw), .fast_ramp_o(framp), .discharge_strength_o(disch),
    .startup_current_floor_o(floor_sel), .ramp_time_select_o(ramp));
  conv_i2c_target conv_i2c_target_inst_b (.clk_i(clk_i), .rst_i(rst_i), .bus(link_b),
    .en_pin_i(1'b1), .converter_on_o(), .fast_slew_select_o(), .hiccup_protect_enable_o(),
    .vout_code_o(), .vout_mv_o(), .forced_pulse_width_select_o(), .fast_ramp_o(),
    .discharge_strength_o(), .startup_current_floor_o(), .ramp_time_select_o());
  conv_i2c_assertions conv_i2c_assertions_inst (.clk_i(clk_i), .rst_i(rst_i),
    .ctl_scl_o(link_a.ctl_scl_o), .ctl_scl_oe_n(link_a.ctl_scl_oe_n),
    .ctl_sda_o(link_a.ctl_sda_o), .ctl_sda_oe_n(link_a.ctl_sda_oe_n),
    .tgt_sda_o(link_a.tgt_sda_o), .tgt_sda_oe_n(link_a.tgt_sda_oe_n),
    .scl(link_a.scl), .sda(link_a.sda));

  // Verdict and end of run
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Pseudo-random source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // One classic bus cycle, held until acknowledged
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat,
                    output logic [31:0] rd);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_sel <= 4'hF;
    wb_adr <= adr;
    wb_dat <= dat;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 20);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
    if (n >= 20)
    begin
      mismatches++;
      end_sim();
    end
  endtask

  // Poll status until the controller is idle
  task automatic idle(output logic [31:0] s);
    int n;
    n = 0;
    do
    begin
      wb(1'b0, STATUS_OFS, 32'h0000_0000, s);
      n++;
    end
    while (s[STAT_BUSY_BIT] !== 1'b0 && n < 3000);
    if (n >= 3000)
    begin
      mismatches++;
      end_sim();
    end
  endtask

  // One link transfer ordered through the controller
  task automatic xfer(input logic rdb, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] g);
    logic [31:0] s;
    wb(1'b1, CMD_OFS, {15'h0000, rdb, a, d}, s);
    idle(s);
    `CHK("nack flag", 1'b0, s[STAT_NACK_BIT])
    g = s[15:8];
  endtask

  // Model: defaults, reads and writes
  task automatic mdef();
    m_a = 8'h08;
    m_v = 8'h5C;
    m_b = 8'h45;
  endtask
  function automatic logic [7:0] mrd(input logic [7:0] a);
    if (a == 8'h02)
      return m_a;
    if (a == 8'h03)
      return m_v;
    if (a == 8'h05)
      return m_b;
    return 8'h00;
  endfunction
  task automatic mwr(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h02)
      m_a = d & 8'h0D;
    else if (a == 8'h03)
      m_v = d;
    else if (a == 8'h05)
      m_b = d;
  endtask

  // Compare every converter output with the model
  task automatic ports();
    int mv;
    mv = (m_v <= 8'hB4) ? 1000 + 25 * int'(m_v) : 5500;
    `CHK("conv on", m_a[0] & en_pin, conv_on)
    `CHK("fast slew", m_a[3], fast_slew)
    `CHK("hiccup", m_a[2], hiccup)
    `CHK("vout code", m_v, vout_code)
    `CHK("vout mv", 13'(mv), vout_mv)
    `CHK("ctrl b", m_b, {fpw, framp, disch, floor_sel, ramp})
  endtask

  // Raw link bit-banging on the second link
  task automatic bq();
    repeat (BQ) @(posedge clk_i);
  endtask
  task automatic bbit(input logic b, output logic s);
    link_b.ctl_sda_oe_n <= b;
    bq();
    link_b.ctl_scl_oe_n <= 1'b1;
    bq();
    s = link_b.sda;
    bq();
    link_b.ctl_scl_oe_n <= 1'b0;
    bq();
  endtask
  task automatic bstop();
    link_b.ctl_scl_oe_n <= 1'b0;
    bq();
    link_b.ctl_sda_oe_n <= 1'b0;
    bq();
    link_b.ctl_scl_oe_n <= 1'b1;
    bq();
    link_b.ctl_sda_oe_n <= 1'b1;
    bq();
  endtask

  // Main sequence
  initial
  begin
    link_b.ctl_scl_o = 1'b0;
    link_b.ctl_sda_o = 1'b0;
    link_b.ctl_scl_oe_n = 1'b1;
    link_b.ctl_sda_oe_n = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    idle(st);
    mdef();
    ports();
    foreach (offs[i])
    begin
      xfer(1'b1, offs[i], 8'h00, got);
      `CHK("reset read", mrd(offs[i]), got)
    end
    for (int i = 0; i < 7; i++)
    begin
      r = rnd();
      ra = (i < 5) ? offs[i] : 8'h03;
      r[7:0] = (i == 5) ? 8'hB4 : (i == 6) ? 8'hB5 : r[7:0];
      xfer(1'b0, ra, r[7:0], got);
      mwr(ra, r[7:0]);
      xfer(1'b1, ra, 8'h00, got);
      `CHK("read back", mrd(ra), got)
      ports();
    end
    for (int k = 0; k < 2; k++)
    begin
      r = rnd();
      xfer(1'b0, 8'h02, 8'hFF, got);
      xfer(1'b0, 8'h03, r[7:0], got);
      mwr(8'h02, 8'hFF);
      mwr(8'h03, r[7:0]);
      ports();
      if (k == 0)
      begin
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        idle(st);
      end
      else
      begin
        en_pin <= 1'b0;
        repeat (6) @(posedge clk_i);
        `CHK("conv off", 1'b0, conv_on)
        en_pin <= 1'b1;
        repeat (6) @(posedge clk_i);
      end
      mdef();
      ports();
    end
    bstop();
    foreach (atab[i])
    begin
      link_b.ctl_sda_oe_n <= 1'b1;
      link_b.ctl_scl_oe_n <= 1'b1;
      bq();
      link_b.ctl_sda_oe_n <= 1'b0;
      bq();
      link_b.ctl_scl_oe_n <= 1'b0;
      bq();
      for (int j = 7; j >= 0; j--)
        bbit(atab[i][j], ack);
      bbit(1'b1, ack);
      bstop();
      `CHK("addr ack", (i != 0), ack)
    end
    end_sim();
  end
endmodule
